// file: src/watchdog_timer_nmi_reset.v
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ns
`include "watchdog_consts.vh"
module watchdog_timer_nmi_reset #(
    parameter CNT_W = 25
) (
    input wire CLK,
    input wire RST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    input wire IDLE_MODE,
    input wire DEBUG_MODE,
    output reg NMI_REQ,
    output reg SYS_RESET_REQ,
    output reg CLOCK_SEL_UNDIV,
    output reg TIMEOUT_OUT_N,
    output reg IRQ
);
// ----------------------------------------
// input synchronisers
// ----------------------------------------
reg idle_meta_reg;
reg idle_sync_reg;
reg dbg_meta_reg;
reg dbg_sync_reg;
// mode levels come from other logic, so two stages each
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        idle_meta_reg <= 1'b0;
        idle_sync_reg <= 1'b0;
    end else begin
        idle_meta_reg <= IDLE_MODE;
        idle_sync_reg <= idle_meta_reg;
    end
end
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        dbg_meta_reg <= 1'b0;
        dbg_sync_reg <= 1'b0;
    end else begin
        dbg_meta_reg <= DEBUG_MODE;
        dbg_sync_reg <= dbg_meta_reg;
    end
end
// ----------------------------------------
// bus decode
// ----------------------------------------
localparam [7:0] MISC_BASE = `ADDR_MISC_BASE;
localparam [7:0] MODE_ADDR = {4'h0, `ADDR_MODE};
localparam [7:0] CMD_ADDR = {4'h0, `ADDR_COMMAND};
localparam [7:0] NMI_ADDR = {4'h0, `ADDR_NMI_FLAGS};
localparam [7:0] STAT_ADDR = {4'h0, `ADDR_IRQ_STATUS};
localparam [7:0] ICLR_ADDR = {MISC_BASE[7:4], `ADDR_IRQ_CLEAR};
localparam [7:0] IEN_ADDR = {MISC_BASE[7:4], `ADDR_IRQ_ENABLE};
wire bus_req;
wire wr_req;
wire wr_mode;
wire wr_cmd;
wire wr_iclr;
wire wr_ien;
wire wr_nmi;
wire rd_req;
wire [7:0] cmd;
// ack high blocks a second take of the same request
assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
// only the low byte carries meaning, so only its lane enables writes
assign wr_req = bus_req & WB_WE_I & WB_SEL_I[0];
assign wr_mode = wr_req & (WB_ADR_I == MODE_ADDR);
assign wr_cmd = wr_req & (WB_ADR_I == CMD_ADDR);
assign wr_iclr = wr_req & (WB_ADR_I == ICLR_ADDR);
assign wr_ien = wr_req & (WB_ADR_I == IEN_ADDR);
assign wr_nmi = wr_req & (WB_ADR_I == NMI_ADDR);
assign rd_req = bus_req & ~WB_WE_I;
assign cmd = WB_DAT_I[7:0];
// ----------------------------------------
// mode and enable
// ----------------------------------------
localparam [1:0] ST_RUN = 2'b01;
localparam [1:0] ST_OFF = 2'b10;
reg [7:0] mode_reg;
reg [7:0] mode_next;
reg [1:0] state_reg;
reg [1:0] state_next;
wire enable_bit;
wire [2:0] period_sel;
wire idle_run;
wire action_rst;
wire running;
wire code_clear;
wire code_disable;
assign enable_bit = mode_reg[`MODE_ENABLE_BIT];
assign period_sel = mode_reg[`MODE_PERIOD_HI:`MODE_PERIOD_LO];
assign idle_run = mode_reg[`MODE_IDLE_BIT];
assign action_rst = mode_reg[`MODE_ACTION_BIT];
assign running = (state_reg == ST_RUN);
assign code_clear = wr_cmd & (cmd == `CODE_CLEAR);
// enable bit must read 0 first, so one stray write cannot stop us
assign code_disable = wr_cmd & (cmd == `CODE_DISABLE) & ~enable_bit;
always @* begin
    mode_next = mode_reg;
    if (wr_mode) begin
        mode_next = WB_DAT_I[7:0] & `MODE_WRITE_MASK;
    end
end
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_RUN: begin
            if (code_disable) begin
                state_next = ST_OFF;
            end
        end
        ST_OFF: begin
            if (wr_mode & WB_DAT_I[`MODE_ENABLE_BIT]) begin
                state_next = ST_RUN;
            end
        end
        default: begin
            state_next = ST_RUN;
        end
    endcase
end
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        mode_reg <= `MODE_RESET_VALUE;
        state_reg <= ST_RUN;
    end else begin
        mode_reg <= mode_next;
        state_reg <= state_next;
    end
end
// ----------------------------------------
// binary counter
// ----------------------------------------
localparam [4:0] EXP_0 = `PERIOD_EXP_BASE;
localparam [4:0] EXP_1 = `PERIOD_EXP_BASE + `PERIOD_EXP_STEP;
localparam [4:0] EXP_2 = `PERIOD_EXP_BASE + 2 * `PERIOD_EXP_STEP;
localparam [4:0] EXP_3 = `PERIOD_EXP_BASE + 3 * `PERIOD_EXP_STEP;
localparam [4:0] EXP_4 = `PERIOD_EXP_BASE + 4 * `PERIOD_EXP_STEP;
localparam [4:0] EXP_5 = `PERIOD_EXP_BASE + 5 * `PERIOD_EXP_STEP;
reg [CNT_W-1:0] count_reg;
reg [CNT_W-1:0] count_next;
reg [CNT_W-1:0] limit;
reg [4:0] limit_exp;
wire [2:0] sel_eff;
wire halted;
wire overflow;
assign sel_eff = (period_sel > `PERIOD_MAX_CODE) ?
    `PERIOD_MAX_CODE : period_sel; // prohibited codes use longest
assign halted = dbg_sync_reg |
    (idle_sync_reg & ~idle_run);
assign overflow = running & ~halted & (count_reg == limit);
always @* begin
    case (sel_eff)
        3'h0: limit_exp = EXP_0;
        3'h1: limit_exp = EXP_1;
        3'h2: limit_exp = EXP_2;
        3'h3: limit_exp = EXP_3;
        3'h4: limit_exp = EXP_4;
        3'h5: limit_exp = EXP_5;
        default: limit_exp = EXP_5;
    endcase
end
always @* begin
    // ones below the chosen bit give 2^n-1, also when n equals CNT_W
    limit = ~({CNT_W{1'b1}} << limit_exp);
end
// counts only while running and not halted
always @* begin
    count_next = count_reg;
    if (code_clear | code_disable | overflow) begin
        count_next = {CNT_W{1'b0}};
    end else if (running & ~halted) begin
        count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
end
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        count_reg <= {CNT_W{1'b0}};
    end else begin
        count_reg <= count_next;
    end
end
// ----------------------------------------
// overflow actions
// ----------------------------------------
localparam [5:0] HOLD_INIT = `RESET_HOLD_STATES;
localparam [5:0] HOLD_STEP = 6'h01;
wire act_irq;
wire act_rst;
reg [5:0] hold_reg;
reg [5:0] hold_next;
reg nmi_flag_reg;
assign act_irq = overflow & ~action_rst;
assign act_rst = overflow & action_rst;
// hold counted here since the request resets the rest externally
always @* begin
    hold_next = hold_reg;
    if (act_rst) begin
        hold_next = HOLD_INIT;
    end else if (hold_reg != 6'h00) begin
        hold_next = hold_reg - HOLD_STEP;
    end
end
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        hold_reg <= 6'h00;
        SYS_RESET_REQ <= 1'b0;
        CLOCK_SEL_UNDIV <= 1'b0;
    end else begin
        hold_reg <= hold_next;
        // request stands while the hold count is not used up
        SYS_RESET_REQ <= (hold_next != 6'h00);
        CLOCK_SEL_UNDIV <= (hold_next != 6'h00);
    end
end
// one-cycle pulse per timeout when the action bit selects interrupt, none in reset action
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        NMI_REQ <= 1'b0;
    end else begin
        NMI_REQ <= act_irq;
    end
end
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        TIMEOUT_OUT_N <= 1'b1;
    end else if (act_irq) begin
        TIMEOUT_OUT_N <= 1'b0;
    end else if (code_clear) begin
        TIMEOUT_OUT_N <= 1'b1;
    end
end
// set wins over a software clear in the same cycle
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        nmi_flag_reg <= 1'b0;
    end else if (act_irq) begin
        nmi_flag_reg <= 1'b1;
    end else if (wr_nmi & WB_DAT_I[`NMI_WDT_FLAG]) begin
        nmi_flag_reg <= 1'b0;
    end
end
// ----------------------------------------
// interrupt status
// ----------------------------------------
reg [1:0] stat_reg;
reg [1:0] ien_reg;
// bit 0 timeout interrupt, bit 1 reset request
wire [1:0] events = {act_rst, act_irq};
genvar i;
generate
for (i = 0; i < 2; i = i + 1) begin : g_stat
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            stat_reg[i] <= 1'b0;
        end else if (events[i]) begin
            stat_reg[i] <= 1'b1;
        end else if (wr_iclr & WB_DAT_I[i]) begin
            stat_reg[i] <= 1'b0;
        end
    end
end
endgenerate
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        ien_reg <= 2'h0;
    end else if (wr_ien) begin
        ien_reg <= WB_DAT_I[1:0];
    end
end
// registered so the level output never glitches
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        IRQ <= 1'b0;
    end else begin
        IRQ <= |(stat_reg & ien_reg);
    end
end
// ----------------------------------------
// read mux and ack
// ----------------------------------------
reg [31:0] rd_data;
reg [31:0] rd_next;
always @* begin
    rd_data = 32'h0000_0000;
    case (WB_ADR_I)
        MODE_ADDR: rd_data = {24'h00_0000, mode_reg};
        NMI_ADDR: rd_data = {31'h0000_0000, nmi_flag_reg};
        STAT_ADDR: rd_data = {30'h0000_0000, stat_reg};
        IEN_ADDR: rd_data = {30'h0000_0000, ien_reg};
        // command and clear registers are write-only and read 0
        default: rd_data = 32'h0000_0000;
    endcase
end
always @* begin
    rd_next = 32'h0000_0000;
    if (rd_req) begin
        rd_next = rd_data;
    end
end
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        WB_ACK_O <= 1'b0;
    end else begin
        WB_ACK_O <= bus_req;
    end
end
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        WB_DAT_O <= 32'h0000_0000;
    end else begin
        WB_DAT_O <= rd_next;
    end
end
endmodule // watchdog_timer_nmi_reset

// file: src/watchdog_consts.vh
`ifndef WATCHDOG_CONSTS_VH
`define WATCHDOG_CONSTS_VH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define ADDR_MODE 4'h0
`define ADDR_COMMAND 4'h4
`define ADDR_NMI_FLAGS 4'h8
`define ADDR_IRQ_STATUS 4'hc
`define ADDR_IRQ_CLEAR 4'h0
`define ADDR_IRQ_ENABLE 4'h4
`define ADDR_MISC_BASE 8'h10
// ----------------------------------------
// mode register fields
// ----------------------------------------
`define MODE_ENABLE_BIT 7
`define MODE_PERIOD_HI 6
`define MODE_PERIOD_LO 4
`define MODE_IDLE_BIT 2
`define MODE_ACTION_BIT 1
`define MODE_RESET_VALUE 8'h82
`define MODE_WRITE_MASK 8'hf6
// ----------------------------------------
// command codes
// ----------------------------------------
`define CODE_DISABLE 8'hb1
`define CODE_CLEAR 8'h4e
// ----------------------------------------
// timing
// ----------------------------------------
`define PERIOD_EXP_BASE 15
`define PERIOD_EXP_STEP 2
`define PERIOD_MAX_CODE 3'h5
`define RESET_HOLD_STATES 32
// ----------------------------------------
// status bits
// ----------------------------------------
`define STAT_TIMEOUT 0
`define STAT_RESET 1
`define NMI_WDT_FLAG 0
`endif

// file: bench/wd_chk.sv
`timescale 1ns/1ns
module wd_chk (
    input wire logic CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic DEBUG_MODE,
    input wire logic NMI_REQ,
    input wire logic SYS_RESET_REQ,
    input wire logic CLOCK_SEL_UNDIV,
    input wire logic TIMEOUT_OUT_N
);
    logic [6:0] hold_reg;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);
    always @(posedge CLK or posedge RST) begin
        if (RST)
            hold_reg <= 7'h00;
        else
            hold_reg <= SYS_RESET_REQ ? hold_reg + 7'h01 : 7'h00;
    end
    a_ack_next: assert property (
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
    a_ack_pulse: assert property (
        WB_ACK_O |=> !WB_ACK_O) else $error("long ack");
    a_nmi_pulse: assert property (
        NMI_REQ |=> !NMI_REQ) else $error("long nmi");
    a_nmi_out_low: assert property (
        NMI_REQ |-> !TIMEOUT_OUT_N) else $error("out not low");
    a_out_low_cause: assert property (
        $fell(TIMEOUT_OUT_N) |-> NMI_REQ) else $error("out low alone");
    a_reset_len: assert property (
        $fell(SYS_RESET_REQ) |-> hold_reg == 7'h20) else $error("bad hold");
    a_clock_undiv: assert property (
        SYS_RESET_REQ |-> CLOCK_SEL_UNDIV) else $error("clock sel");
    a_debug_halt: assert property (
        DEBUG_MODE [*6] |-> !$rose(NMI_REQ) && !$rose(SYS_RESET_REQ))
        else $error("ran in debug");
    cover property ($rose(SYS_RESET_REQ));
    cover property ($rose(NMI_REQ));
    cover property ($rose(TIMEOUT_OUT_N));
endmodule // wd_chk

// file: bench/tb.sv
`timescale 1ns/1ns
module tb;
    logic CLK = 1'b0, RST = 1'b1, IDLE_MODE = 1'b0, DEBUG_MODE = 1'b0;
    logic WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
    logic [7:0] WB_ADR_I = 8'h00;
    logic [3:0] WB_SEL_I = 4'h0;
    logic [31:0] WB_DAT_I = 32'h0, q;
    wire [31:0] WB_DAT_O;
    wire WB_ACK_O, NMI_REQ, SYS_RESET_REQ, CLOCK_SEL_UNDIV;
    wire TIMEOUT_OUT_N, IRQ;
    int bad_count = 0, samples_checked = 0, ticks = 0, stamp = 0, n, t;
    // ----
    // write flag, address, write data, expected read
    // ----
    logic [72:0] tbl [0:8] = '{
        {1'b0, 8'h00, 32'h0, 32'h82},
        {1'b1, 8'h00, 32'hff, 32'h0},
        {1'b0, 8'h00, 32'h0, 32'hf6},
        {1'b1, 8'h00, 32'h82, 32'h0},
        {1'b0, 8'h04, 32'h0, 32'h0},
        {1'b1, 8'h14, 32'h3, 32'h0},
        {1'b0, 8'h18, 32'h0, 32'h0},
        {1'b1, 8'h04, 32'hb1, 32'h0},
        {1'b1, 8'h04, 32'h55, 32'h0}};
    watchdog_timer_nmi_reset dut (.CLK, .RST, .WB_CYC_I, .WB_STB_I,
        .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O,
        .IDLE_MODE, .DEBUG_MODE, .NMI_REQ, .SYS_RESET_REQ, .CLOCK_SEL_UNDIV,
        .TIMEOUT_OUT_N, .IRQ);
    always #2 CLK = ~CLK;
    always @(posedge CLK) ticks <= RST ? 0 : ticks + 1;
    task automatic close_out();
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            $display("BAD at %0t seen %h expected %h", $time, s, e);
            bad_count++;
        end
    endtask
    // stamp keeps the tick of the edge that took the request
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int k;
        k = 0;
        @(posedge CLK);
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_SEL_I} <= {2'b11, w, 4'hf};
        {WB_ADR_I, WB_DAT_I} <= {a, d};
        do begin
            @(posedge CLK);
            k++;
        end while (WB_ACK_O !== 1'b1 && k < 20);
        q = WB_DAT_O;
        stamp = ticks;
        {WB_CYC_I, WB_STB_I} <= 2'b00;
        if (k >= 20) bad_count++;
        if (k >= 20) close_out();
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(q, e);
    endtask
    task automatic wait_ev(input logic nmi);
        int k;
        k = 0;
        while ((nmi ? NMI_REQ : SYS_RESET_REQ) !== 1'b1) begin
            @(posedge CLK);
            #1;
            k++;
            if (k > 40000) bad_count++;
            if (k > 40000) close_out();
        end
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            wb(tbl[i][72], tbl[i][71:64], tbl[i][63:32]);
            if (!tbl[i][72]) check(q, tbl[i][31:0]);
        end
        wait_ev(1'b0);
        check(ticks, 32768);
        check(CLOCK_SEL_UNDIV, 1'b1);
        check(NMI_REQ, 1'b0);
        n = 0;
        while (SYS_RESET_REQ === 1'b1 && n < 99) begin
            @(posedge CLK);
            #1;
            n++;
        end
        check(n, 32);
        check(IRQ, 1'b1);
        rd(8'h0c, 32'h2);
        wb(1'b1, 8'h10, 32'h2);
        rd(8'h0c, 32'h0);
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b1, 8'h04, 32'hb1);
        repeat (200) @(posedge CLK);
        wb(1'b1, 8'h00, 32'h80);
        // debug and idle halts add their lengths to the period
        t = stamp + 32768 + 150;
        @(posedge CLK);
        DEBUG_MODE <= 1'b1;
        repeat (100) @(posedge CLK);
        DEBUG_MODE <= 1'b0;
        repeat (10) @(posedge CLK);
        IDLE_MODE <= 1'b1;
        repeat (50) @(posedge CLK);
        IDLE_MODE <= 1'b0;
        wait_ev(1'b1);
        check(ticks, t);
        check(TIMEOUT_OUT_N, 1'b0);
        check(SYS_RESET_REQ, 1'b0);
        rd(8'h08, 32'h1);
        check(IRQ, 1'b1);
        wb(1'b1, 8'h14, 32'h0);
        check(IRQ, 1'b0);
        wb(1'b1, 8'h04, 32'h4e);
        check(TIMEOUT_OUT_N, 1'b1);
        close_out();
    end
endmodule // tb
bind watchdog_timer_nmi_reset wd_chk chk (.CLK, .RST, .WB_CYC_I, .WB_STB_I,
    .WB_ACK_O, .DEBUG_MODE, .NMI_REQ, .SYS_RESET_REQ, .CLOCK_SEL_UNDIV,
    .TIMEOUT_OUT_N);
